// ==== src/mas_slice.v ====
// Multiply/add/accumulate slice with shift chains and register port
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "mas_map.vh"
module mas_slice (
   input wire clk_sys,
   input wire resetn,
   input wire [17:0] operand_in_a_port,
   input wire [17:0] operand_in_b1,
   input wire [17:0] operand_in_a2,
   input wire [17:0] operand_in_b2,
   input wire [17:0] operand_in_a3,
   input wire [17:0] operand_in_b3,
   input wire [17:0] operand_in_a4,
   input wire [17:0] operand_in_b4,
   input wire [17:0] shift_in_a,
   input wire [17:0] shift_in_b,
   input wire sign_a,
   input wire sign_b,
   input wire add_sub_select_upper,
   input wire add_sub_select_lower,
   input wire acc_sload_upper,
   input wire acc_sload_lower,
   input wire [3:0] stage_ena,
   input wire [3:0] stage_clr,
   input wire [`MAS_AW-1:0] reg_addr,
   input wire [`MAS_DW-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [`MAS_DW-1:0] reg_rdata,
   output reg [17:0] shift_out_a,
   output reg [17:0] shift_out_b,
   output reg [17:0] result_out_port,
   output reg [17:0] result_ob,
   output reg [17:0] result_oc,
   output reg [17:0] result_od,
   output reg [17:0] result_oe,
   output reg [17:0] result_of,
   output reg [17:0] result_og,
   output reg [17:0] result_oh,
   output reg ovf_upper,
   output reg ovf_lower
);

   function [37:0] mas_mul18;
      input [17:0] a;
      input [17:0] b;
      input sa;
      input sb;
      reg signed [18:0] x;
      reg signed [18:0] y;
      begin
         x = {sa & a[17], a};
         y = {sb & b[17], b};
         mas_mul18 = x * y;
      end
   endfunction

   function [19:0] mas_mul9;
      input [8:0] a;
      input [8:0] b;
      input sa;
      input sb;
      reg signed [9:0] x;
      reg signed [9:0] y;
      begin
         x = {sa & a[8], a};
         y = {sb & b[8], b};
         mas_mul9 = x * y;
      end
   endfunction

   function [53:0] mas_as54;
      input [37:0] x;
      input [37:0] y;
      input add;
      reg [53:0] ex;
      reg [53:0] ey;
      begin
         ex = {{16{x[37]}}, x};
         ey = {{16{y[37]}}, y};
         mas_as54 = add ? ex + ey : ex - ey;
      end
   endfunction

   function [35:0] mas_as36;
      input [19:0] x;
      input [19:0] y;
      input add;
      reg [35:0] ex;
      reg [35:0] ey;
      begin
         ex = {{16{x[19]}}, x};
         ey = {{16{y[19]}}, y};
         mas_as36 = add ? ex + ey : ex - ey;
      end
   endfunction

   function [52:0] mas_acc;
      input [51:0] acc;
      input [51:0] p;
      input add;
      input sgn;
      reg [52:0] t;
      begin
         if (add) begin
            t = {sgn & acc[51], acc} + {sgn & p[51], p};
         end else begin
            t = {sgn & acc[51], acc} - {sgn & p[51], p};
         end
         mas_acc = {(sgn ? (t[52] ^ t[51]) : t[52]), t[51:0]};
      end
   endfunction

   reg [`MAS_CFG_BITS-1:0] cfg_reg;
   wire [1:0] mode = cfg_reg[`MAS_CFG_MODE_HI:`MAS_CFG_MODE_LO];
   wire w9 = cfg_reg[`MAS_CFG_W9];
   wire w36 = cfg_reg[`MAS_CFG_W36] & (mode == `MAS_MODE_SIMPLE);
   wire shift_on = cfg_reg[`MAS_CFG_SHIFT] & ~w36;
   wire coef_ser = cfg_reg[`MAS_CFG_COEF_SER];
   wire pipe_en = cfg_reg[`MAS_CFG_PIPE];
   wire out_reg_en = cfg_reg[`MAS_CFG_OUTREG];
   wire [1:0] ctl_lat = cfg_reg[`MAS_CFG_CTL_LAT_HI:`MAS_CFG_CTL_LAT_LO];

   // Register port
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cfg_reg <= `MAS_CFG_RST;
         reg_rdata <= {`MAS_DW{1'b0}};
      end else begin
         if (reg_wr && reg_addr == `MAS_CFG_OFS) begin
            cfg_reg <= reg_wdata[`MAS_CFG_BITS-1:0];
         end
         if (reg_rd && reg_addr == `MAS_CFG_OFS) begin
            reg_rdata <= {{(`MAS_DW-`MAS_CFG_BITS){1'b0}}, cfg_reg};
         end else if (reg_rd && reg_addr == `MAS_STAT_OFS) begin
            reg_rdata <= {{(`MAS_DW-4){1'b0}}, ovf_lower, ovf_upper, mode};
         end else begin
            reg_rdata <= {`MAS_DW{1'b0}};
         end
      end
   end

   // Control pipeline: sign 0/1 stage, add/sub and load 0/1/2 stages
   reg [1:0] sign_d1_reg;
   reg [3:0] ctl_d1_reg;
   reg [3:0] ctl_d2_reg;
   wire [3:0] ctl_raw = {acc_sload_lower, acc_sload_upper,
                         add_sub_select_lower, add_sub_select_upper};
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {sign_d1_reg, ctl_d1_reg, ctl_d2_reg} <= 10'h000;
      end else if (stage_clr[3]) begin
         {sign_d1_reg, ctl_d1_reg, ctl_d2_reg} <= 10'h000;
      end else if (stage_ena[3]) begin
         sign_d1_reg <= {sign_b, sign_a};
         ctl_d1_reg <= ctl_raw;
         ctl_d2_reg <= ctl_d1_reg;
      end
   end
   wire [1:0] sgn = cfg_reg[`MAS_CFG_SIGN_LAT] ? sign_d1_reg : {sign_b, sign_a};
   wire [3:0] ctl = (ctl_lat == 2'h2) ? ctl_d2_reg :
                    (ctl_lat == 2'h1) ? ctl_d1_reg : ctl_raw;
   wire as_up = ctl[0];
   wire as_lo = ctl[1];
   wire ld_up = ctl[2];
   wire ld_lo = ctl[3];

   // Operand sources; wide mode crosses halves into four partials
   wire [71:0] a_flat = {operand_in_a4, operand_in_a3, operand_in_a2,
                         operand_in_a_port};
   wire [71:0] b_flat = {operand_in_b4, operand_in_b3, operand_in_b2, operand_in_b1};

   reg [17:0] a_in_reg [0:3];
   reg [17:0] b_in_reg [0:3];
   integer i;
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (i = 0; i < 4; i = i + 1) begin
            a_in_reg[i] <= 18'h00000;
            b_in_reg[i] <= 18'h00000;
         end
      end else if (stage_clr[0]) begin
         for (i = 0; i < 4; i = i + 1) begin
            a_in_reg[i] <= 18'h00000;
            b_in_reg[i] <= 18'h00000;
         end
      end else if (stage_ena[0]) begin
         if (w36) begin
            a_in_reg[0] <= a_flat[17:0];
            a_in_reg[1] <= a_flat[35:18];
            a_in_reg[2] <= a_flat[17:0];
            a_in_reg[3] <= a_flat[35:18];
            b_in_reg[0] <= b_flat[17:0];
            b_in_reg[1] <= b_flat[17:0];
            b_in_reg[2] <= b_flat[35:18];
            b_in_reg[3] <= b_flat[35:18];
         end else if (shift_on) begin
            a_in_reg[0] <= shift_in_a;
            b_in_reg[0] <= coef_ser ? shift_in_b : b_flat[17:0];
            for (i = 1; i < 4; i = i + 1) begin
               a_in_reg[i] <= a_in_reg[i-1];
               b_in_reg[i] <= coef_ser ? b_in_reg[i-1] : b_flat[18*i +: 18];
            end
         end else begin
            for (i = 0; i < 4; i = i + 1) begin
               a_in_reg[i] <= a_flat[18*i +: 18];
               b_in_reg[i] <= b_flat[18*i +: 18];
            end
         end
      end
   end

   // Chain onward to the next slice
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         shift_out_a <= 18'h00000;
         shift_out_b <= 18'h00000;
      end else begin
         shift_out_a <= shift_on ? a_in_reg[3] : 18'h00000;
         shift_out_b <= shift_on ? b_in_reg[3] : 18'h00000;
      end
   end

   // Multipliers and partial-product registers
   wire [37:0] p18 [0:3];
   wire [19:0] p9l [0:3];
   wire [19:0] p9h [0:3];
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_mul
         wire sa = w36 ? (sgn[0] & (g % 2 == 1)) : sgn[0];
         wire sb = w36 ? (sgn[1] & (g >= 2)) : sgn[1];
         wire [37:0] c18 = mas_mul18(a_in_reg[g], b_in_reg[g], sa, sb);
         wire [19:0] c9l = mas_mul9(a_in_reg[g][8:0], b_in_reg[g][8:0], sgn[0], sgn[1]);
         wire [19:0] c9h = mas_mul9(a_in_reg[g][17:9], b_in_reg[g][17:9], sgn[0], sgn[1]);
         reg [37:0] r18_reg;
         reg [19:0] r9l_reg;
         reg [19:0] r9h_reg;
         always @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               {r18_reg, r9l_reg, r9h_reg} <= 78'h0;
            end else if (stage_clr[1]) begin
               {r18_reg, r9l_reg, r9h_reg} <= 78'h0;
            end else if (stage_ena[1]) begin
               r18_reg <= c18;
               r9l_reg <= c9l;
               r9h_reg <= c9h;
            end
         end
         assign p18[g] = pipe_en ? r18_reg : c18;
         assign p9l[g] = pipe_en ? r9l_reg : c9l;
         assign p9h[g] = pipe_en ? r9h_reg : c9h;
      end
   endgenerate

   // First-stage adders and summation
   wire [53:0] s0 = mas_as54(p18[0], p18[1], as_up);
   wire [53:0] s1 = mas_as54(p18[2], p18[3], as_lo);
   wire [35:0] s0l = mas_as36(p9l[0], p9l[1], as_up);
   wire [35:0] s0h = mas_as36(p9h[0], p9h[1], as_up);
   wire [35:0] s1l = mas_as36(p9l[2], p9l[3], as_lo);
   wire [35:0] s1h = mas_as36(p9h[2], p9h[3], as_lo);
   wire [53:0] f18 = s0 + s1;
   wire [35:0] f9l = s0l + s1l;
   wire [35:0] f9h = s0h + s1h;

   // Wide product from four shifted partials
   wire [73:0] w_hi = {{36{p18[3][37]}}, p18[3]};
   wire [73:0] w_mid = {{36{p18[1][37]}}, p18[1]} + {{36{p18[2][37]}}, p18[2]};
   wire [73:0] w_lo = {{36{p18[0][37]}}, p18[0]};
   wire [73:0] wide = (w_hi << 36) + (w_mid << 18) + w_lo;

   // Accumulators on second and fourth multipliers
   reg [51:0] acc_up_reg;
   reg [51:0] acc_lo_reg;
   wire sgn_any = sgn[0] | sgn[1];
   wire [51:0] m_up = w9 ? {{32{p9l[1][19]}}, p9l[1]} : {{14{p18[1][37]}}, p18[1]};
   wire [51:0] m_lo = w9 ? {{32{p9l[3][19]}}, p9l[3]} : {{14{p18[3][37]}}, p18[3]};
   wire [52:0] st_up = mas_acc(acc_up_reg, m_up, as_up, sgn_any);
   wire [52:0] st_lo = mas_acc(acc_lo_reg, m_lo, as_lo, sgn_any);
   wire [51:0] acc_up_next = ld_up ? m_up : st_up[51:0];
   wire [51:0] acc_lo_next = ld_lo ? m_lo : st_lo[51:0];
   wire is_mac = (mode == `MAS_MODE_MAC);
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {acc_up_reg, acc_lo_reg, ovf_upper, ovf_lower} <= 106'h0;
      end else if (stage_clr[2]) begin
         {acc_up_reg, acc_lo_reg, ovf_upper, ovf_lower} <= 106'h0;
      end else if (stage_ena[2]) begin
         acc_up_reg <= is_mac ? acc_up_next : 52'h0;
         acc_lo_reg <= is_mac ? acc_lo_next : 52'h0;
         ovf_upper <= is_mac & ~ld_up & st_up[52];
         ovf_lower <= is_mac & ~ld_lo & st_lo[52];
      end
   end

   // Output selection into eight 18-bit rows
   reg [143:0] res_flat;
   integer j;
   always @* begin
      res_flat = 144'h0;
      j = 0;
      case (mode)
         `MAS_MODE_SIMPLE: begin
            if (w36) begin
               res_flat = {72'h0, wide[71:0]};
            end else if (w9) begin
               for (j = 0; j < 4; j = j + 1) begin
                  res_flat[36*j +: 36] = {p9h[j][17:0], p9l[j][17:0]};
               end
            end else begin
               for (j = 0; j < 4; j = j + 1) begin
                  res_flat[36*j +: 36] = p18[j][35:0];
               end
            end
         end
         `MAS_MODE_MAC: begin
            res_flat = {18'h0, {2{acc_lo_next[51]}}, acc_lo_next,
                        18'h0, {2{acc_up_next[51]}}, acc_up_next};
         end
         `MAS_MODE_ADD2: begin
            if (w9) begin
               res_flat = {s1h, s1l, s0h, s0l};
            end else begin
               res_flat = {18'h0, s1, 18'h0, s0};
            end
         end
         `MAS_MODE_ADD4: begin
            if (w9) begin
               res_flat = {36'h0, f9h, 36'h0, f9l};
            end else begin
               res_flat = {90'h0, f18};
            end
         end
         default: begin
            res_flat = 144'h0;
         end
      endcase
   end

   // Optional extra output stage ahead of the row flops
   reg [143:0] mid_reg;
   wire [143:0] out_src = out_reg_en ? mid_reg : res_flat;
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {mid_reg, result_out_port, result_ob, result_oc, result_od,
          result_oe, result_of, result_og, result_oh} <= 288'h0;
      end else if (stage_clr[2]) begin
         {mid_reg, result_out_port, result_ob, result_oc, result_od,
          result_oe, result_of, result_og, result_oh} <= 288'h0;
      end else if (stage_ena[2]) begin
         mid_reg <= res_flat;
         result_out_port <= out_src[17:0];
         result_ob <= out_src[35:18];
         result_oc <= out_src[53:36];
         result_od <= out_src[71:54];
         result_oe <= out_src[89:72];
         result_of <= out_src[107:90];
         result_og <= out_src[125:108];
         result_oh <= out_src[143:126];
      end
   end

endmodule // mas_slice

// ==== src/mas_map.vh ====
// Constants for the multiply/add/accumulate slice
`ifndef MAS_MAP_VH
`define MAS_MAP_VH
// Register offsets (byte addresses)
`define MAS_CFG_OFS 4'h0
`define MAS_STAT_OFS 4'h4
// Configuration field positions
`define MAS_CFG_MODE_LO 0
`define MAS_CFG_MODE_HI 1
`define MAS_CFG_W9 2
`define MAS_CFG_W36 3
`define MAS_CFG_SHIFT 4
`define MAS_CFG_COEF_SER 5
`define MAS_CFG_PIPE 6
`define MAS_CFG_OUTREG 7
`define MAS_CFG_SIGN_LAT 8
`define MAS_CFG_CTL_LAT_LO 9
`define MAS_CFG_CTL_LAT_HI 10
`define MAS_CFG_BITS 11
`define MAS_CFG_RST 11'h000
// Status field positions
`define MAS_STAT_OVF_UP 2
`define MAS_STAT_OVF_LO 3
// Operating modes
`define MAS_MODE_SIMPLE 2'h0
`define MAS_MODE_MAC 2'h1
`define MAS_MODE_ADD2 2'h2
`define MAS_MODE_ADD4 2'h3
// Register bus widths
`define MAS_AW 4
`define MAS_DW 16
`endif

// ==== tb/mas_fabric.sv ====
// Fabric model feeding operands and controls to the slice
`timescale 1ns/1ps
module mas_fabric (
   input wire clk_sys,
   input wire resetn,
   input wire [143:0] ops_d,
   input wire [5:0] ctl_d,
   output logic [143:0] ops_q,
   output logic [5:0] ctl_q
);
   // Rows A1,B1..A4,B4 in fixed order
   // One width and one static mode for every feed
   // Wide-product post arithmetic done inside the slice
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ops_q <= '0;
         ctl_q <= '0;
      end else begin
         ops_q <= ops_d;
         ctl_q <= ctl_d;
      end
   end
endmodule // mas_fabric

// ==== tb/mas_slice_sva.sv ====
// Port checker for the multiply/add/accumulate slice
`timescale 1ns/1ps
`include "mas_map.vh"
module mas_slice_chk (
   input wire clk_sys,
   input wire resetn,
   input wire [17:0] operand_in_a_port,
   input wire [17:0] operand_in_b1,
   input wire [17:0] operand_in_a2,
   input wire [17:0] operand_in_b2,
   input wire sign_a,
   input wire sign_b,
   input wire add_sub_select_upper,
   input wire [3:0] stage_ena,
   input wire [3:0] stage_clr,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   input wire [17:0] shift_out_a,
   input wire [17:0] shift_out_b,
   input wire [17:0] result_out_port,
   input wire [17:0] result_ob,
   input wire [17:0] result_oc,
   input wire ovf_upper,
   input wire ovf_lower
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic [10:0] cfg;
   logic [2:0] age;
   // Shadow of the configuration word
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cfg <= 11'h000;
         age <= 3'h0;
      end else if (reg_wr && reg_addr == `MAS_CFG_OFS) begin
         cfg <= reg_wdata[10:0];
         age <= 3'h0;
      end else if (age != 3'h7) begin
         age <= age + 3'h1;
      end
   end
   sequence s_feed(logic [10:0] v);
      cfg == v && age != 3'h0 && stage_ena == 4'hf && stage_clr == 4'h0 && !sign_a && !sign_b
      ##1 stage_ena == 4'hf && stage_clr == 4'h0;
   endsequence
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not idle");
   a_cfg_readback: assert property (reg_rd && reg_addr == `MAS_CFG_OFS
      |=> reg_rdata == {5'h00, cfg}) else $error("config readback wrong");
   a_stat_mode: assert property (reg_rd && reg_addr == `MAS_STAT_OFS
      |=> reg_rdata[1:0] == cfg[1:0] && reg_rdata[15:4] == 12'h000) else $error("status wrong");
   a_unmapped_zero: assert property (reg_rd && reg_addr != `MAS_CFG_OFS
      && reg_addr != `MAS_STAT_OFS |=> reg_rdata == 16'h0000) else $error("unmapped read");
   a_ovf_mac_only: assert property (age > 3'h2 && cfg[1:0] != `MAS_MODE_MAC
      |-> !ovf_upper && !ovf_lower) else $error("overflow outside accumulate");
   a_shift_off: assert property (age > 3'h2 && !cfg[4]
      |-> shift_out_a == 18'h0 && shift_out_b == 18'h0) else $error("chain not idle");
   a_simple_prod: assert property (s_feed(11'h300)
      |=> {result_ob, result_out_port} == $past(operand_in_a_port, 2) * $past(operand_in_b1, 2))
      else $error("simple product wrong");
   a_add2_sum: assert property (s_feed(11'h302) |=> ($past(add_sub_select_upper, 2) ->
      {result_oc, result_ob, result_out_port} == $past(operand_in_a_port, 2)
      * $past(operand_in_b1, 2) + $past(operand_in_a2, 2) * $past(operand_in_b2, 2)))
      else $error("pair sum wrong");
   a_clear_rows: assert property (stage_clr[2]
      |=> result_out_port == 18'h0 && result_ob == 18'h0) else $error("clear ignored");
   a_ena_hold: assert property (!stage_ena[2] && !stage_clr[2]
      |=> $stable(result_out_port)) else $error("output moved while disabled");
endmodule // mas_slice_chk

// ==== tb/tb.sv ====
// Self-checking bench for the multiply/add/accumulate slice
`timescale 1ns/1ps
`include "mas_map.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
   logic clk_sys = 0;
   logic resetn = 0;
   logic [143:0] ops_d = '0;
   logic [5:0] ctl_d = '0;
   wire [143:0] ops;
   wire [5:0] ctl;
   logic [17:0] sh_a = '0;
   logic [17:0] sh_b = '0;
   logic [3:0] ena = 4'hf;
   logic [3:0] clr = 4'h0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wd = 16'h0000;
   logic wr = 0;
   logic rd = 0;
   wire [15:0] rdat;
   wire [17:0] rw [0:7];
   wire ovu;
   wire ovl;
   int err_total = 0;
   int samples_checked = 0;
   longint acc_u = 0;
   longint acc_l = 0;
   logic [145:0] expq [$];
   logic [10:0] cfg = 11'h000;
   mas_fabric i_fab (.clk_sys(clk_sys), .resetn(resetn), .ops_d(ops_d), .ctl_d(ctl_d),
      .ops_q(ops), .ctl_q(ctl));
   mas_slice i_dut (.clk_sys(clk_sys), .resetn(resetn), .operand_in_a_port(ops[17:0]),
      .operand_in_b1(ops[35:18]), .operand_in_a2(ops[53:36]), .operand_in_b2(ops[71:54]),
      .operand_in_a3(ops[89:72]), .operand_in_b3(ops[107:90]), .operand_in_a4(ops[125:108]),
      .operand_in_b4(ops[143:126]), .shift_in_a(sh_a), .shift_in_b(sh_b), .sign_a(ctl[0]),
      .sign_b(ctl[1]), .add_sub_select_upper(ctl[2]), .add_sub_select_lower(ctl[3]),
      .acc_sload_upper(ctl[4]), .acc_sload_lower(ctl[5]), .stage_ena(ena), .stage_clr(clr),
      .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
      .shift_out_a(), .shift_out_b(), .result_out_port(rw[0]), .result_ob(rw[1]),
      .result_oc(rw[2]), .result_od(rw[3]), .result_oe(rw[4]), .result_of(rw[5]),
      .result_og(rw[6]), .result_oh(rw[7]), .ovf_upper(ovu), .ovf_lower(ovl));
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   function automatic longint sx(logic [17:0] a, logic s, int n);
      longint v;
      v = longint'(a) & ((longint'(1) << n) - 1);
      if (s && a[n-1]) v = v - (longint'(1) << n);
      return v;
   endfunction
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic wreg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [15:0] x);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      `CHK("rdata", x, rdat)
   endtask
   task automatic step(input logic [143:0] o, input logic [5:0] c);
      logic [145:0] e;
      logic [145:0] g;
      longint p [4];
      longint s0;
      longint s1;
      e = '0;
      for (int i = 0; i < 4; i++) begin
         p[i] = sx(o[36*i+:18], c[0], 18) * sx(o[36*i+18+:18], c[1], 18);
         if (cfg[2]) begin
            e[36*i+:18] = 18'(sx(o[36*i+:18], c[0], 9) * sx(o[36*i+18+:18], c[1], 9));
            e[36*i+18+:18] = 18'(sx(o[36*i+9+:9], c[0], 9) * sx(o[36*i+27+:9], c[1], 9));
         end else e[36*i+:36] = p[i][35:0];
      end
      s0 = c[2] ? p[0] + p[1] : p[0] - p[1];
      s1 = c[3] ? p[2] + p[3] : p[2] - p[3];
      case (cfg[1:0])
         `MAS_MODE_SIMPLE: if (cfg[3]) e = {74'h0, 72'({o[53:36], o[17:0]})
            * 72'({o[71:54], o[35:18]})};
         `MAS_MODE_MAC: begin
            acc_u = c[4] ? p[1] : (c[2] ? acc_u + p[1] : acc_u - p[1]);
            acc_l = c[5] ? p[3] : (c[3] ? acc_l + p[3] : acc_l - p[3]);
            e = {20'h0, acc_l[53:0], 18'h0, acc_u[53:0]};
         end
         `MAS_MODE_ADD2: e = {20'h0, s1[53:0], 18'h0, s0[53:0]};
         default: e = {92'h0, s0[53:0] + s1[53:0]};
      endcase
      @(posedge clk_sys);
      ops_d <= o;
      ctl_d <= c;
      sh_a <= 18'($urandom);
      sh_b <= 18'($urandom);
      expq.push_back(e);
      @(negedge clk_sys);
      if (expq.size() == 4 + int'(cfg[6]) + int'(cfg[7])) begin
         e = expq.pop_front();
         g = {ovl, ovu, rw[7], rw[6], rw[5], rw[4], rw[3], rw[2], rw[1], rw[0]};
         `CHK("rows", e[143:0], g[143:0])
         `CHK("ovf", e[145:144], g[145:144])
      end
   endtask
   initial begin
      #200000;
      err_total++;
      wrap_up();
   end
   initial begin
      logic [143:0] o;
      logic [5:0] c;
      logic [10:0] cfgs [7];
      o = '0;
      c = '0;
      void'($urandom(32'ha261c26c));
      cfgs = '{11'h300, 11'h3c0, 11'h304, 11'h308, 11'h301, 11'h302, 11'h303};
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      rreg(`MAS_CFG_OFS, 16'h0000);
      wreg(4'h8, 16'hffff);
      rreg(4'h8, 16'h0000);
      rreg(`MAS_STAT_OFS, 16'h0000);
      foreach (cfgs[k]) begin
         repeat (3) step(o, c);
         expq.delete();
         cfg = cfgs[k];
         wreg(`MAS_CFG_OFS, {5'h00, cfg});
         rreg(`MAS_CFG_OFS, {5'h00, cfg});
         rreg(`MAS_STAT_OFS, {14'h0, cfg[1:0]});
         for (int n = 0; n < 24; n++) begin
            o = 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
            c = 6'($urandom);
            if (cfg[3]) c[1:0] = 2'b00;
            if (cfg[1:0] == `MAS_MODE_MAC) c[1:0] = 2'b11;
            if (n == 0) c[5:4] = 2'b11;
            step(o, c);
         end
      end
      @(posedge clk_sys);
      ena <= 4'hb;
      ops_d <= ~ops_d;
      repeat (3) @(posedge clk_sys);
      clr <= 4'h4;
      ena <= 4'hf;
      @(posedge clk_sys);
      clr <= 4'h0;
      @(negedge clk_sys);
      `CHK("cleared", 36'h0, {rw[1], rw[0]})
      wrap_up();
   end
endmodule // tb
bind mas_slice mas_slice_chk i_chk (.clk_sys(clk_sys), .resetn(resetn),
   .operand_in_a_port(operand_in_a_port), .operand_in_b1(operand_in_b1),
   .operand_in_a2(operand_in_a2), .operand_in_b2(operand_in_b2), .sign_a(sign_a),
   .sign_b(sign_b), .add_sub_select_upper(add_sub_select_upper), .stage_ena(stage_ena),
   .stage_clr(stage_clr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shift_out_a(shift_out_a),
   .shift_out_b(shift_out_b), .result_out_port(result_out_port), .result_ob(result_ob),
   .result_oc(result_oc), .ovf_upper(ovf_upper), .ovf_lower(ovf_lower));
